// File: core/plh_top.sv
// Purpose: host port to a 256-entry 24-bit colour look-up table
// Assumes: host I/O strobes and pixels come from logic on CORE_CLK_I
// Notes: a table access takes the table for one clock from repaint
//
// Notes on behaviour
// RULE_01 - table holds 256 entries of 24 bits
// RULE_02 - host reads: set read pointer, three reads
// RULE_03 - pointer write restarts a partial read triple
// RULE_04 - after third read, pointer advances and wraps
// RULE_05 - host writes: set write pointer, three writes
// RULE_06 - pointer write restarts a partial write triple
// RULE_07 - third written byte updates entry, pointer advances
// RULE_08 - read pointer address reads back state byte
// RULE_09 - state bits show last pointer write address
// RULE_10 - one shared index; write pointer reads it
// RULE_11 - data port reads and writes the indexed entry
// RULE_12 - compat mode stores host bits 5-0 high
// RULE_13 - compat mode returns table bits 7-2 low
// RULE_14 - signature select redirects data port to signatures
// RULE_15 - whole triple moves in one clock
// RULE_16 - stolen clock repeats the previous pixel colour
// RULE_17 - host sets pointer then three uninterrupted accesses
// RULE_18 - index and table need no reset value
// RULE_19 - pixel ANDed with mask, mask resets to ones
// RULE_20 - host accesses decoded synchronously, triple moves safely
`timescale 1ns/1ps
module plh_top
import plh_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic [plh_pkg::IO_AW-1:0] IO_ADDR_I,
    input wire logic IO_WR_I,
    input wire logic IO_RD_I,
    input wire logic [7:0] IO_WDATA_I,
    output logic [7:0] IO_RDATA_O,
    output logic IO_RVALID_O,
    input wire logic [2:0] DEPTH_SEL_I,
    input wire logic SIG_SEL_I,
    input wire logic PIX_VLD_I,
    input wire logic [plh_pkg::IDX_W-1:0] PIX_I,
    output logic [plh_pkg::ENTRY_W-1:0] RGB_O,
    output logic RGB_VLD_O,
    output logic [plh_pkg::ENTRY_W-1:0] SIG_O
);
    import plh_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [IDX_W-1:0] index;
    logic [IDX_W-1:0] next_index;
    plh_byte_t byte_sel;
    plh_byte_t next_byte_sel;
    logic [1:0] last_wr;
    logic [1:0] next_last_wr;
    logic [7:0] pixel_mask;
    logic [7:0] next_pixel_mask;
    logic [ENTRY_W-1:0] rd_hold;
    logic [ENTRY_W-1:0] next_rd_hold;
    logic [2*COMP_W-1:0] wr_hold;
    logic [2*COMP_W-1:0] next_wr_hold;
    logic [ENTRY_W-1:0] sig;
    logic [ENTRY_W-1:0] next_sig;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [ENTRY_W-1:0] rgb;
    logic [ENTRY_W-1:0] next_rgb;
    logic rgb_vld;
    logic next_rgb_vld;

    // ------------------------------------------------------------
    // decode and table port arbitration
    // ------------------------------------------------------------
    logic ptr_wr;
    logic data_wr;
    logic data_rd;
    logic compat;
    logic host_use;
    logic ram_we;
    logic [IDX_W-1:0] host_addr;
    logic [IDX_W-1:0] ram_addr;
    logic [ENTRY_W-1:0] ram_wdata;
    logic [ENTRY_W-1:0] ram_rdata;
    logic [7:0] wr_mapped;
    logic [7:0] rd_byte;
    logic [7:0] rd_mapped;
    logic [IDX_W-1:0] index_inc;

    assign ptr_wr = IO_WR_I && (IO_ADDR_I == ADDR_READ_POINTER
        || IO_ADDR_I == ADDR_WRITE_POINTER);
    assign data_wr = IO_WR_I && IO_ADDR_I == ADDR_BYTE_PORT;
    assign data_rd = IO_RD_I && IO_ADDR_I == ADDR_BYTE_PORT;
    assign compat = DEPTH_SEL_I == DEPTH_COMPAT;
    assign index_inc = index + 8'h01; // [RULE_04] [RULE_07]

    always_comb
    begin
        ram_we = 1'b0;
        host_use = 1'b0;
        host_addr = index;
        ram_wdata = {wr_hold, wr_mapped};
        if (ptr_wr && IO_ADDR_I == ADDR_READ_POINTER)
        begin
            // fetch the whole entry for the coming read triple
            host_use = 1'b1; // [RULE_15]
            host_addr = IO_WDATA_I;
        end
        else if (!SIG_SEL_I && byte_sel == BYTE_BLUE && data_wr)
        begin
            ram_we = 1'b1; // [RULE_07] [RULE_11] [RULE_15]
            host_use = 1'b1;
        end
        else if (!SIG_SEL_I && byte_sel == BYTE_BLUE && data_rd)
        begin
            // refetch at the advanced index
            host_use = 1'b1; // [RULE_04]
            host_addr = index_inc;
        end
        ram_addr = host_use ? host_addr : (PIX_I & pixel_mask); // [RULE_19]
    end

    plh_lut_ram #(.DEPTH(LUT_ENTRIES), .AW(IDX_W), .DW(ENTRY_W)) u_ram
    (
        .clk_i(CORE_CLK_I),
        .we_i(ram_we),
        .addr_i(ram_addr),
        .wdata_i(ram_wdata),
        .rdata_o(ram_rdata)
    ); // [RULE_01] [RULE_18]

    always_comb
    begin
        case (byte_sel)
            BYTE_RED: rd_byte = rd_hold[RED_LSB +: COMP_W];
            BYTE_GREEN: rd_byte = rd_hold[GREEN_LSB +: COMP_W];
            default: rd_byte = rd_hold[BLUE_LSB +: COMP_W];
        endcase
    end

    plh_byte_map u_map
    (
        .compat_i(compat),
        .host_wr_i(IO_WDATA_I),
        .table_rd_i(rd_byte),
        .table_wr_o(wr_mapped),
        .host_rd_o(rd_mapped)
    ); // [RULE_12] [RULE_13]

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_index = index;
        next_byte_sel = byte_sel;
        next_last_wr = last_wr;
        next_pixel_mask = pixel_mask;
        next_rd_hold = host_use ? ram_rdata : rd_hold;
        next_wr_hold = wr_hold;
        next_sig = sig;
        next_rdata = rdata;
        next_rvalid = IO_RD_I; // [RULE_20]
        next_rgb = rgb;
        next_rgb_vld = PIX_VLD_I;
        if (PIX_VLD_I && !host_use)
        begin
            next_rgb = ram_rdata;
        end
        // while the host holds the table the last colour is kept [RULE_16]
        if (ptr_wr)
        begin
            next_index = IO_WDATA_I; // [RULE_10]
            next_byte_sel = BYTE_RED; // [RULE_03] [RULE_06]
            next_last_wr = IO_ADDR_I[1:0]; // [RULE_09]
        end
        else if (IO_WR_I && IO_ADDR_I == ADDR_PIXEL_MASK)
        begin
            next_pixel_mask = IO_WDATA_I; // [RULE_19]
        end
        else if (data_wr)
        begin
            if (SIG_SEL_I)
            begin
                case (byte_sel)
                    BYTE_RED: next_sig[RED_LSB +: COMP_W] = IO_WDATA_I; // [RULE_14]
                    BYTE_GREEN: next_sig[GREEN_LSB +: COMP_W] = IO_WDATA_I;
                    default: next_sig[BLUE_LSB +: COMP_W] = IO_WDATA_I;
                endcase
            end
            else if (byte_sel == BYTE_RED)
            begin
                next_wr_hold[COMP_W +: COMP_W] = wr_mapped; // [RULE_12]
            end
            else if (byte_sel == BYTE_GREEN)
            begin
                next_wr_hold[0 +: COMP_W] = wr_mapped;
            end
            else
            begin
                next_index = index_inc; // [RULE_07]
            end
        end
        if (data_wr || data_rd)
        begin
            case (byte_sel)
                BYTE_RED: next_byte_sel = BYTE_GREEN;
                BYTE_GREEN: next_byte_sel = BYTE_BLUE;
                default: next_byte_sel = BYTE_RED;
            endcase
        end
        if (data_rd && !SIG_SEL_I && byte_sel == BYTE_BLUE)
        begin
            next_index = index_inc; // [RULE_04]
        end
        if (IO_RD_I)
        begin
            case (IO_ADDR_I)
                ADDR_READ_POINTER: next_rdata = {6'h00, last_wr}; // [RULE_08]
                ADDR_WRITE_POINTER: next_rdata = index; // [RULE_10]
                ADDR_PIXEL_MASK: next_rdata = pixel_mask;
                ADDR_BYTE_PORT:
                begin
                    if (SIG_SEL_I)
                    begin
                        case (byte_sel)
                            BYTE_RED: next_rdata = sig[RED_LSB +: COMP_W]; // [RULE_14]
                            BYTE_GREEN: next_rdata = sig[GREEN_LSB +: COMP_W];
                            default: next_rdata = sig[BLUE_LSB +: COMP_W];
                        endcase
                    end
                    else
                    begin
                        next_rdata = rd_mapped; // [RULE_11] [RULE_13]
                    end
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            index <= INDEX_RST;
            byte_sel <= BYTE_RED;
            last_wr <= STATE_RST;
            pixel_mask <= PIXEL_MASK_RST; // [RULE_19]
            rd_hold <= '0;
            wr_hold <= '0;
            sig <= '0;
            rdata <= 8'h00;
            rvalid <= 1'b0;
            rgb <= '0;
            rgb_vld <= 1'b0;
        end
        else
        begin
            index <= next_index;
            byte_sel <= next_byte_sel;
            last_wr <= next_last_wr;
            pixel_mask <= next_pixel_mask;
            rd_hold <= next_rd_hold;
            wr_hold <= next_wr_hold;
            sig <= next_sig;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            rgb <= next_rgb;
            rgb_vld <= next_rgb_vld;
        end
    end

    assign IO_RDATA_O = rdata;
    assign IO_RVALID_O = rvalid;
    assign RGB_O = rgb;
    assign RGB_VLD_O = rgb_vld;
    assign SIG_O = sig;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence s_third_lut_read;
        data_rd && !SIG_SEL_I && !ptr_wr && byte_sel == BYTE_BLUE;
    endsequence

    sequence s_third_lut_write;
        data_wr && !SIG_SEL_I && byte_sel == BYTE_BLUE;
    endsequence

    chk_ptr_restart: assert property (ptr_wr |=> byte_sel == BYTE_RED) // [RULE_03]
        else $error("pointer write did not restart the triple");
    chk_read_advance: assert property (s_third_lut_read |=> index == $past(index) + 8'h01) // [RULE_04]
        else $error("third read did not advance the index");
    chk_write_commit: assert property (s_third_lut_write |-> ram_we && ram_addr == index) // [RULE_07]
        else $error("third write did not update the indexed entry");
    chk_state_bits: assert property (IO_WR_I && IO_ADDR_I == ADDR_READ_POINTER
        |=> last_wr == 2'b11) // [RULE_09]
        else $error("state bits wrong after read pointer write");
    chk_state_readback: assert property (IO_RD_I && IO_ADDR_I == ADDR_READ_POINTER
        |=> IO_RDATA_O == {6'h00, $past(last_wr)} && IO_RVALID_O) // [RULE_08]
        else $error("read pointer address did not return state");
    chk_compat_read: assert property (data_rd && !SIG_SEL_I && compat
        |=> IO_RDATA_O[7:6] == 2'b00) // [RULE_13]
        else $error("compat read left high bits set");
    chk_steal_hold: assert property (host_use && PIX_VLD_I |=> RGB_O == $past(RGB_O)) // [RULE_16]
        else $error("stolen clock changed the pixel colour");
    chk_mask_apply: assert property (!host_use |-> ram_addr == (PIX_I & pixel_mask)) // [RULE_19]
        else $error("pixel not masked before lookup");
    chk_write_restart: assert property (data_wr && byte_sel == BYTE_GREEN ##[1:2] ptr_wr
        |=> byte_sel == BYTE_RED) // [RULE_06]
        else $error("partial write triple not abandoned");
endmodule

// File: core/plh_pkg.sv
// Purpose: shared constants for the colour look-up table host port
// Assumes: byte-wide I/O accesses decoded on the core clock
// Notes: port addresses are the full I/O addresses of the port
package plh_pkg;
    // ------------------------------------------------------------
    // port addresses
    // ------------------------------------------------------------
    localparam int IO_AW = 16;
    localparam logic [IO_AW-1:0] ADDR_PIXEL_MASK = 16'h03c6;
    localparam logic [IO_AW-1:0] ADDR_READ_POINTER = 16'h03c7;
    localparam logic [IO_AW-1:0] ADDR_WRITE_POINTER = 16'h03c8;
    localparam logic [IO_AW-1:0] ADDR_BYTE_PORT = 16'h03c9;

    // ------------------------------------------------------------
    // table shape and field values
    // ------------------------------------------------------------
    localparam int LUT_ENTRIES = 256;
    localparam int IDX_W = 8;
    localparam int COMP_W = 8;
    localparam int ENTRY_W = 24;
    localparam logic [7:0] PIXEL_MASK_RST = 8'hff;
    localparam logic [IDX_W-1:0] INDEX_RST = 8'h00;
    localparam logic [2:0] DEPTH_COMPAT = 3'h0;
    localparam logic [1:0] STATE_RST = 2'h0;
    localparam int RED_LSB = 16;
    localparam int GREEN_LSB = 8;
    localparam int BLUE_LSB = 0;

    typedef enum logic [1:0]
    {
        BYTE_RED = 2'b00,
        BYTE_GREEN = 2'b01,
        BYTE_BLUE = 2'b10
    } plh_byte_t;
endpackage

// File: core/plh_lut_ram.sv
// Purpose: single-port colour table storage
// Assumes: one address per clock, shared by video and host
// Notes: contents are not reset
`timescale 1ns/1ps
module plh_lut_ram
#(
    parameter int DEPTH = 256,
    parameter int AW = 8,
    parameter int DW = 24
)
(
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[addr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[addr_i];
endmodule

// File: core/plh_byte_map.sv
// Purpose: maps host bytes to and from table components
// Assumes: compat selects the 6-bit component view
// Notes: purely combinational
`timescale 1ns/1ps
module plh_byte_map
(
    input wire logic compat_i,
    input wire logic [7:0] host_wr_i,
    input wire logic [7:0] table_rd_i,
    output logic [7:0] table_wr_o,
    output logic [7:0] host_rd_o
);
    always_comb
    begin
        if (compat_i)
        begin
            table_wr_o = {host_wr_i[5:0], 2'b00};
            host_rd_o = {2'b00, table_rd_i[7:2]};
        end
        else
        begin
            table_wr_o = host_wr_i;
            host_rd_o = table_rd_i;
        end
    end
endmodule

// File: dv/plh_host_model.sv
// Purpose: host model issuing byte I/O accesses to the table port
// Assumes: one strobe per byte, changed only just after a rising edge
// Notes: released write data is inverted so a stale byte never matches
`timescale 1ns/1ps
module plh_host_model
import plh_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic [plh_pkg::IO_AW-1:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    import plh_pkg::*;

    initial
    begin
        addr_o = '0;
        wr_o = 1'h0;
        rd_o = 1'h0;
        wdata_o = 8'h00;
    end

    // --------------------------------------------------------------
    // byte accesses
    // --------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'h1;
        @(posedge clk_i);
        wr_o <= 1'h0;
        wdata_o <= ~d;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'h1;
        @(posedge clk_i);
        rd_o <= 1'h0;
        ok = 1'h0;
        d = 8'h00;
        for (int k = 0; k < 4 && !ok; k++)
        begin
            @(posedge clk_i);
            if (rvalid_i === 1'h1)
            begin
                ok = 1'h1;
                d = rdata_i;
            end
        end
    endtask
endmodule

// File: dv/palette_lut_host_port_bench.sv
// Purpose: self-checking bench for the colour table host port
// Assumes: host and video share one clock
// Notes: a model of the table predicts every data byte and pixel
`timescale 1ns/1ps
module palette_lut_host_port_bench
import plh_pkg::*;
;
    logic clk = 1'h0;
    logic rst_n;
    logic [15:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic io_rvalid;
    logic [2:0] depth_sel;
    logic sig_sel;
    logic pix_vld;
    logic [7:0] pix;
    logic [23:0] rgb;
    logic rgb_vld;
    logic [23:0] sig;
    logic [23:0] tbl [256];
    logic [7:0] ix;
    logic [7:0] msk;
    logic [31:0] r;
    int mismatches;
    int n_tests;
    int seed = 32'h77df6a23;

    always #5 clk = ~clk;

    plh_top i_plh_top
    (
        .CORE_CLK_I(clk),
        .RST_N_I(rst_n),
        .IO_ADDR_I(io_addr),
        .IO_WR_I(io_wr),
        .IO_RD_I(io_rd),
        .IO_WDATA_I(io_wdata),
        .IO_RDATA_O(io_rdata),
        .IO_RVALID_O(io_rvalid),
        .DEPTH_SEL_I(depth_sel),
        .SIG_SEL_I(sig_sel),
        .PIX_VLD_I(pix_vld),
        .PIX_I(pix),
        .RGB_O(rgb),
        .RGB_VLD_O(rgb_vld),
        .SIG_O(sig)
    );

    plh_host_model i_plh_host_model
    (
        .clk_i(clk),
        .rdata_i(io_rdata),
        .rvalid_i(io_rvalid),
        .addr_o(io_addr),
        .wr_o(io_wr),
        .rd_o(io_rd),
        .wdata_o(io_wdata)
    );

    // --------------------------------------------------------------
    // expectations and checks
    // --------------------------------------------------------------
    function automatic logic [7:0] stored(input logic [7:0] d);
        return (depth_sel == DEPTH_COMPAT) ? {d[5:0], 2'h0} : d;
    endfunction

    function automatic logic [7:0] shown(input logic [7:0] t);
        return (depth_sel == DEPTH_COMPAT) ? {2'h0, t[7:2]} : t;
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic ok;
        i_plh_host_model.rd(a, d, ok);
        if (ok !== 1'h1)
        begin
            mismatches++;
            $display("Error read answer expected 1 seen 0");
            wrap_up();
        end
        else
        begin
            chk(what, {16'h0, exp}, {16'h0, d});
        end
    endtask

    task automatic setw(input logic [7:0] i);
        i_plh_host_model.wr(ADDR_WRITE_POINTER, i);
        ix = i;
    endtask

    task automatic setr(input logic [7:0] i);
        i_plh_host_model.wr(ADDR_READ_POINTER, i);
        ix = i;
    endtask

    task automatic wtri(input logic [23:0] v);
        for (int b = 2; b >= 0; b--)
            i_plh_host_model.wr(ADDR_BYTE_PORT, v[8*b +: 8]);
        tbl[ix] = {stored(v[23:16]), stored(v[15:8]), stored(v[7:0])};
        ix++;
    endtask

    task automatic rtri();
        for (int b = 2; b >= 0; b--)
            rdc(ADDR_BYTE_PORT, shown(tbl[ix][8*b +: 8]), "data byte");
        ix++;
    endtask

    task automatic vid(input logic [7:0] p);
        @(posedge clk);
        pix_vld <= 1'h1;
        pix <= p;
        @(posedge clk);
        pix_vld <= 1'h0;
        pix <= ~p;
        #1;
        chk("pixel valid", 24'h1, {23'h0, rgb_vld});
        chk("pixel colour", tbl[p & msk], rgb);
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        rst_n = 1'h0;
        depth_sel = 3'h1;
        sig_sel = 1'h0;
        pix_vld = 1'h0;
        pix = 8'h00;
        msk = 8'hff;
        mismatches = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        rdc(ADDR_PIXEL_MASK, PIXEL_MASK_RST, "pixel mask");
        setw(8'h00);
        repeat (256)
        begin
            r = $random(seed);
            wtri(r[23:0]);
        end
        rdc(ADDR_WRITE_POINTER, 8'h00, "index");
        rdc(ADDR_READ_POINTER, 8'h00, "state");
        setr(8'hfe);
        repeat (3) rtri();
        rdc(ADDR_WRITE_POINTER, 8'h01, "index");
        rdc(ADDR_READ_POINTER, 8'h03, "state");
        // partial triples are abandoned by either pointer write
        setw(8'h40);
        i_plh_host_model.wr(ADDR_BYTE_PORT, 8'h5a);
        i_plh_host_model.wr(ADDR_BYTE_PORT, 8'ha5);
        setr(8'h40);
        setw(8'h40);
        r = $random(seed);
        wtri(r[23:0]);
        setr(8'h40);
        rdc(ADDR_BYTE_PORT, shown(tbl[8'h40][23:16]), "data byte");
        setw(8'h40);
        rtri();
        setr(8'h40);
        rtri();
        // six-bit compatibility view
        depth_sel <= DEPTH_COMPAT;
        setw(8'h80);
        repeat (2)
        begin
            r = $random(seed);
            wtri(r[23:0]);
        end
        setr(8'h80);
        repeat (2) rtri();
        depth_sel <= 3'h7;
        setr(8'h80);
        repeat (2) rtri();
        r = $random(seed);
        msk = r[7:0];
        i_plh_host_model.wr(ADDR_PIXEL_MASK, msk);
        repeat (40)
        begin
            r = $random(seed);
            vid(r[7:0]);
        end
        // a pointer write takes the table while a pixel is looked up
        @(posedge clk);
        pix_vld <= 1'h1;
        pix <= 8'h80;
        setr(8'h81);
        pix_vld <= 1'h0;
        #1;
        chk("stolen pixel", tbl[8'h80 & msk], rgb);
        // signature registers take the data port
        sig_sel <= 1'h1;
        setw(8'h10);
        r = $random(seed);
        for (int b = 2; b >= 0; b--)
            i_plh_host_model.wr(ADDR_BYTE_PORT, r[8*b +: 8]);
        #1;
        chk("signature", r[23:0], sig);
        for (int b = 2; b >= 0; b--)
            rdc(ADDR_BYTE_PORT, r[8*b +: 8], "signature byte");
        sig_sel <= 1'h0;
        setr(8'h10);
        rtri();
        wrap_up();
    end
endmodule
